// [src/bsf_pkg.sv]
package bsf_pkg;
    localparam logic [7:0]  A_CTRL    = 8'h00;
    localparam logic [7:0]  A_PER_ACT = 8'h04;
    localparam logic [7:0]  A_PER_SLP = 8'h08;
    localparam logic [7:0]  A_STAT    = 8'h0C;
    localparam logic [7:0]  A_CLR     = 8'h10;
    localparam logic [7:0]  A_IEN     = 8'h14;
    localparam logic [7:0]  A_INFO    = 8'h18;
    localparam logic [1:0]  CTRL_RST  = 2'h0;
    localparam logic [31:0] PER_ACT_RST = 32'h0EE6B280;
    localparam logic [31:0] PER_SLP_RST = 32'h3B9ACA00;
    localparam logic [7:0]  C_S     = 8'h53;
    localparam logic [7:0]  C_T     = 8'h54;
    localparam logic [7:0]  C_1     = 8'h31;
    localparam logic [7:0]  C_COMMA = 8'h2C;
    localparam logic [7:0]  C_QM    = 8'h3F;
    localparam logic [7:0]  C_LF    = 8'h0A;
    localparam logic [7:0]  C_CR    = 8'h0D;
    localparam logic [7:0]  STG_FINISHED = 8'h05;
    localparam logic [10:0] PIN_LIVE = 11'h7BE;
    localparam logic [31:0] FLD_END  = 32'h80A2808A;
    localparam logic [4:0]  NIB_LAST = 5'h1F;
    localparam logic [1:0]  HEAD_LAST = 2'h3;
    localparam logic [2:0]  REQ_LAST  = 3'h5;
    localparam int          SNAP_W    = 128;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_HEAD  = 3'b001,
        S_DIG   = 3'b011,
        S_COMMA = 3'b010,
        S_SUM   = 3'b110,
        S_EOL   = 3'b111
    } bsf_state_t;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction
endpackage

// [src/bsf_req_parser.sv]
`timescale 1ns/10ps
// Spots a request sentence: name, a comma, '?' and a line end (CR or LF).
module bsf_req_parser (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    output logic            req_q
);
    logic [2:0] idx_q;
    logic [7:0] exp_c;
    logic       hit;

    always_comb begin
        case (idx_q)
            3'h0:    exp_c = bsf_pkg::C_S;
            3'h1:    exp_c = bsf_pkg::C_T;
            3'h2:    exp_c = bsf_pkg::C_1;
            3'h3:    exp_c = bsf_pkg::C_COMMA;
            3'h4:    exp_c = bsf_pkg::C_QM;
            default: exp_c = bsf_pkg::C_LF;
        endcase
        hit = (rx_data == exp_c) || (idx_q == bsf_pkg::REQ_LAST && rx_data == bsf_pkg::C_CR);
    end

    // A stray character restarts the match, but an 'S' may already open a new name.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q <= 3'h0;
            req_q <= 1'b0;
        end else begin
            req_q <= rx_valid && hit && idx_q == bsf_pkg::REQ_LAST;
            if (rx_valid) begin
                if (hit) begin
                    idx_q <= (idx_q == bsf_pkg::REQ_LAST) ? 3'h0 : idx_q + 3'h1;
                end else begin
                    idx_q <= (rx_data == bsf_pkg::C_S) ? 3'h1 : 3'h0;
                end
            end
        end
    end
endmodule // bsf_req_parser

// [src/bsf_framer.sv]
`timescale 1ns/10ps
module bsf_framer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata_q,
    output logic             pready_q,
    output logic             pslverr_q,
    output logic             irq_q,
    input  wire logic [7:0]  charge_stage,
    input  wire logic [7:0]  charge_fault,
    input  wire logic [15:0] fault_param,
    input  wire logic [31:0] stage_seconds,
    input  wire logic [4:0]  data_valid,
    input  wire logic        can_charger,
    input  wire logic [6:0]  prot_lo,
    input  wire logic [3:0]  prot_hi,
    input  wire logic [3:0]  warn_in,
    input  wire logic [10:0] pin_in,
    input  wire logic [10:0] pin_mapped,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic [7:0]       tx_data_q,
    output logic             tx_valid_q,
    input  wire logic        tx_ready
);
    bsf_pkg::bsf_state_t st_q, st_d;
    logic [1:0]   ctrl_q;
    logic [31:0]  per_act_q, per_slp_q, tmr_q, per;
    logic [1:0]   stat_q, ien_q;
    logic         due_q, req_pend_q, req_pulse, tick, start, acc, wr, sent;
    logic [127:0] snap_q, snap_d;
    logic [4:0]   nib_q, nib_d;
    logic [1:0]   hidx_q, hidx_d;
    logic         sidx_q, sidx_d, accept;
    logic [7:0]   sum_q, chr_d;
    logic [7:0]   batt, warn;
    logic [15:0]  prot;

    function automatic logic known(input logic [7:0] a);
        known = a inside {bsf_pkg::A_CTRL, bsf_pkg::A_PER_ACT, bsf_pkg::A_PER_SLP,
                          bsf_pkg::A_STAT, bsf_pkg::A_CLR, bsf_pkg::A_IEN, bsf_pkg::A_INFO};
    endfunction

    bsf_req_parser u_req (
        .pclk    (pclk),
        .presetn (presetn),
        .rx_data (rx_data),
        .rx_valid(rx_valid),
        .req_q   (req_pulse)
    );

    // One wait state gives every answer a registered pready, prdata and pslverr.
    assign acc = psel && penable;
    assign wr  = acc && pready_q && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= acc && !pready_q;
            pslverr_q <= acc && !pready_q && !known(paddr);
            prdata_q  <= 32'h0;
            if (acc && !pready_q && !pwrite) begin
                case (paddr)
                    bsf_pkg::A_CTRL:    prdata_q <= {30'h0, ctrl_q};
                    bsf_pkg::A_PER_ACT: prdata_q <= per_act_q;
                    bsf_pkg::A_PER_SLP: prdata_q <= per_slp_q;
                    bsf_pkg::A_STAT:    prdata_q <= {30'h0, stat_q};
                    bsf_pkg::A_IEN:     prdata_q <= {30'h0, ien_q};
                    bsf_pkg::A_INFO:    prdata_q <= {24'h0, 3'h0, due_q, req_pend_q, st_q};
                    default:            prdata_q <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= bsf_pkg::CTRL_RST;
            per_act_q <= bsf_pkg::PER_ACT_RST;
            per_slp_q <= bsf_pkg::PER_SLP_RST;
            ien_q     <= 2'h0;
        end else if (wr) begin
            if (paddr == bsf_pkg::A_CTRL)    ctrl_q    <= pwdata[1:0];
            if (paddr == bsf_pkg::A_PER_ACT) per_act_q <= pwdata;
            if (paddr == bsf_pkg::A_PER_SLP) per_slp_q <= pwdata;
            if (paddr == bsf_pkg::A_IEN)     ien_q     <= pwdata[1:0];
        end
    end

    // Sticky events: bit 0 sentence sent, bit 1 request seen; a new event beats a clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 2'h0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~((wr && paddr == bsf_pkg::A_CLR) ? pwdata[1:0] : 2'h0))
                      | {req_pulse, sent};
            irq_q  <= |(stat_q & ien_q);
        end
    end

    // The period follows the sleep bit at once; a zero period behaves as one cycle.
    assign per  = ctrl_q[1] ? per_slp_q : per_act_q;
    assign tick = ctrl_q[0] && (tmr_q + 32'h1 >= per);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_q <= 32'h0;
        end else if (!ctrl_q[0] || tick) begin
            tmr_q <= 32'h0;
        end else begin
            tmr_q <= tmr_q + 32'h1;
        end
    end

    // A tick or request that lands while a sentence is in flight waits for the next one.
    assign start = (st_q == bsf_pkg::S_IDLE) && (due_q || req_pend_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            due_q      <= 1'b0;
            req_pend_q <= 1'b0;
        end else begin
            due_q      <= tick || (due_q && !start);
            req_pend_q <= req_pulse || (req_pend_q && !start);
        end
    end

    assign batt = {2'h0, data_valid[4],
                   (charge_stage == bsf_pkg::STG_FINISHED) && !can_charger,
                   data_valid[3:0]};
    assign prot = {2'h0, prot_hi, 3'h0, prot_lo};
    assign warn = {2'h0, warn_in[3], 2'h0, warn_in[2:0]};
    assign snap_d = {charge_stage, charge_fault, fault_param, stage_seconds,
                     batt, prot, warn,
                     21'h0, pin_in & pin_mapped & bsf_pkg::PIN_LIVE};

    assign accept = tx_valid_q && tx_ready;

    // Next character once the present one is taken; each field ends in a comma.
    always_comb begin
        st_d   = st_q;
        nib_d  = nib_q;
        hidx_d = hidx_q;
        sidx_d = sidx_q;
        chr_d  = tx_data_q;
        case (st_q)
            bsf_pkg::S_HEAD: begin
                // The index names the header character now on the line, so 'S' is zero.
                hidx_d = hidx_q + 2'h1;
                case (hidx_q)
                    2'h0:    chr_d = bsf_pkg::C_T;
                    2'h1:    chr_d = bsf_pkg::C_1;
                    2'h2:    chr_d = bsf_pkg::C_COMMA;
                    default: chr_d = bsf_pkg::hex_char(snap_q[127:124]);
                endcase
                if (hidx_q == bsf_pkg::HEAD_LAST) begin
                    st_d  = bsf_pkg::S_DIG;
                    nib_d = 5'h0;
                end
            end
            bsf_pkg::S_DIG: begin
                if (bsf_pkg::FLD_END[nib_q]) begin
                    st_d  = bsf_pkg::S_COMMA;
                    chr_d = bsf_pkg::C_COMMA;
                end else begin
                    nib_d = nib_q + 5'h1;
                    chr_d = bsf_pkg::hex_char(snap_q[123:120]);
                end
            end
            bsf_pkg::S_COMMA: begin
                if (nib_q == bsf_pkg::NIB_LAST) begin
                    st_d   = bsf_pkg::S_SUM;
                    sidx_d = 1'b0;
                    chr_d  = bsf_pkg::hex_char(sum_q[7:4]);
                end else begin
                    st_d  = bsf_pkg::S_DIG;
                    nib_d = nib_q + 5'h1;
                    chr_d = bsf_pkg::hex_char(snap_q[127:124]);
                end
            end
            bsf_pkg::S_SUM: begin
                sidx_d = 1'b1;
                chr_d  = bsf_pkg::hex_char(sum_q[3:0]);
                if (sidx_q) begin
                    st_d  = bsf_pkg::S_EOL;
                    chr_d = bsf_pkg::C_LF;
                end
            end
            bsf_pkg::S_EOL: st_d = bsf_pkg::S_IDLE;
            default:        st_d = bsf_pkg::S_IDLE;
        endcase
    end

    assign sent = accept && st_q == bsf_pkg::S_EOL;

    // The fields are frozen at the start so one sentence never mixes two samples.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= bsf_pkg::S_IDLE;
            snap_q     <= '0;
            nib_q      <= 5'h0;
            hidx_q     <= 2'h0;
            sidx_q     <= 1'b0;
            sum_q      <= 8'h0;
            tx_data_q  <= 8'h0;
            tx_valid_q <= 1'b0;
        end else if (start) begin
            st_q       <= bsf_pkg::S_HEAD;
            snap_q     <= snap_d;
            hidx_q     <= 2'h0;
            sum_q      <= bsf_pkg::C_S;
            tx_data_q  <= bsf_pkg::C_S;
            tx_valid_q <= 1'b1;
        end else if (accept) begin
            st_q       <= st_d;
            nib_q      <= nib_d;
            hidx_q     <= hidx_d;
            sidx_q     <= sidx_d;
            tx_data_q  <= chr_d;
            tx_valid_q <= st_d != bsf_pkg::S_IDLE;
            // A field's last digit shifts too, so the comma state already sees the next field.
            if (st_q == bsf_pkg::S_DIG) begin
                snap_q <= {snap_q[123:0], 4'h0};
            end
            if (st_d inside {bsf_pkg::S_HEAD, bsf_pkg::S_DIG, bsf_pkg::S_COMMA}) begin
                sum_q <= sum_q + chr_d;
            end
        end
    end

    sequence seq_take;
        tx_valid_q && tx_ready;
    endsequence

    sequence seq_begin;
        st_q == bsf_pkg::S_IDLE && start;
    endsequence

    chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pready_q |=> pready_q ##1 !pready_q)
        else $error("APB answer not after exactly one wait state");

    chk_period_start: assert property (@(posedge pclk) disable iff (!presetn)
        tick && st_q == bsf_pkg::S_IDLE |=> ##1 st_q == bsf_pkg::S_HEAD)
        else $error("Periodic tick did not open a sentence");

    chk_request_answer: assert property (@(posedge pclk) disable iff (!presetn)
        req_pulse && st_q == bsf_pkg::S_IDLE |=> ##1 tx_valid_q && tx_data_q == bsf_pkg::C_S)
        else $error("Request was not answered with a sentence");

    chk_head_order: assert property (@(posedge pclk) disable iff (!presetn)
        (seq_begin ##1 seq_take) |=> tx_data_q == bsf_pkg::C_T)
        else $error("Sentence name out of order");

    chk_digit_hex: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == bsf_pkg::S_DIG |-> tx_data_q inside {[8'h30:8'h39], [8'h41:8'h46]})
        else $error("Field digit is not upper-case hex");

    chk_field_comma: assert property (@(posedge pclk) disable iff (!presetn)
        seq_take and st_q == bsf_pkg::S_DIG and bsf_pkg::FLD_END[nib_q]
        |=> tx_data_q == bsf_pkg::C_COMMA)
        else $error("Field did not end in a comma");

    chk_snap_fields: assert property (@(posedge pclk) disable iff (!presetn)
        seq_begin |=> snap_q[127:64] == $past({charge_stage, charge_fault, fault_param,
                                                stage_seconds}))
        else $error("Stage, fault or duration fields wrong");

    chk_batt_flags: assert property (@(posedge pclk) disable iff (!presetn)
        seq_begin |=> snap_q[63:62] == 2'h0 && snap_q[60] ==
            $past(charge_stage == bsf_pkg::STG_FINISHED && !can_charger))
        else $error("Battery status flags wrong");

    chk_prot_flags: assert property (@(posedge pclk) disable iff (!presetn)
        seq_begin |=> snap_q[55:54] == 2'h0 && snap_q[49:47] == 3'h0
            && snap_q[39:38] == 2'h0 && snap_q[36:35] == 2'h0)
        else $error("Reserved protection or warning bit set");

    chk_pin_flags: assert property (@(posedge pclk) disable iff (!presetn)
        seq_begin |=> snap_q[0] == 1'b0 && snap_q[6] == 1'b0
            && snap_q[10:1] == ($past(pin_in[10:1] & pin_mapped[10:1]) & 10'h3DF))
        else $error("Pin status flags wrong");

    chk_line_end_idle: assert property (@(posedge pclk) disable iff (!presetn)
        seq_take and st_q == bsf_pkg::S_EOL |=> !tx_valid_q && st_q == bsf_pkg::S_IDLE)
        else $error("Line end did not close the sentence");

    chk_sent_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        sent |=> stat_q[0])
        else $error("Sent event was not recorded");

    chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        irq_q == $past(|(stat_q & ien_q)))
        else $error("Interrupt does not follow enabled status");
endmodule // bsf_framer

// [verif/bsf_display_model.sv]
`timescale 1ns/10ps
// Far side of the text link: takes characters with random stalls and sends request lines.
module bsf_display_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    output logic            tx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_valid
);
    logic stall_en;

    initial begin
        stall_en = 1'b1;
        tx_ready = 1'b0;
        rx_data  = 8'h00;
        rx_valid = 1'b0;
    end

    // Stalls are random so that the framer must hold each character until it is taken.
    always @(posedge pclk) begin
        tx_ready <= presetn && (stall_en ? ($urandom_range(3) != 0) : 1'b1);
    end

    task automatic send_line(input string s);
        foreach (s[i]) begin
            @(posedge pclk);
            rx_data  <= s[i];
            rx_valid <= 1'b1;
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        // The idle line shows the inverse of the last character, never a stale copy.
        rx_data  <= ~s[s.len() - 1];
    endtask
endmodule // bsf_display_model

// [verif/bms_status_sentence_framer_tb.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module bms_status_sentence_framer_tb;
    logic        pclk, presetn, psel, penable, pwrite, can_charger;
    logic        pready_q, pslverr_q, irq_q, rx_valid, tx_valid_q, tx_ready, vld_d;
    logic [7:0]  paddr, charge_stage, charge_fault, rx_data, tx_data_q, e;
    logic [31:0] pwdata, prdata_q, stage_seconds, seed;
    logic [15:0] fault_param;
    logic [4:0]  data_valid;
    logic [6:0]  prot_lo;
    logic [3:0]  prot_hi, warn_in;
    logic [10:0] pin_in, pin_mapped;
    byte unsigned exp_q[$];
    byte unsigned line[$];
    int          starts[$];
    int          checked, miscompares, cyc;

    bsf_framer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .irq_q(irq_q),
        .charge_stage(charge_stage), .charge_fault(charge_fault), .fault_param(fault_param),
        .stage_seconds(stage_seconds), .data_valid(data_valid), .can_charger(can_charger),
        .prot_lo(prot_lo), .prot_hi(prot_hi), .warn_in(warn_in), .pin_in(pin_in),
        .pin_mapped(pin_mapped), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready));
    bsf_display_model dsp (.pclk(pclk), .presetn(presetn), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic final_report();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A hang anywhere ends the run through the same report.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            $display("unexpected at %0t: timeout", $time);
            final_report();
        end
    end

    // Every accepted character is matched against the oldest expected one.
    always @(posedge pclk) begin
        vld_d <= tx_valid_q;
        if (presetn && tx_valid_q === 1'b1 && vld_d !== 1'b1) starts.push_back(cyc);
        if (presetn && tx_valid_q === 1'b1 && tx_ready) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("unexpected at %0t: extra character", $time);
            end else begin
                e = exp_q.pop_front();
                `CHK(tx_data_q, e)
            end
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready_q !== 1'b1);
        r = prdata_q;
        err = pslverr_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        err;
        apb(1'b1, a, d, r, err);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xerr);
        logic [31:0] r;
        logic        err;
        apb(1'b0, a, 32'h0, r, err);
        `CHK(r, x)
        `CHK(err, xerr)
    endtask

    task automatic put(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            line.push_back(v[i*4 +: 4] < 4'hA ? 8'h30 + v[i*4 +: 4] : 8'h37 + v[i*4 +: 4]);
        end
        line.push_back(8'h2C);
    endtask

    task automatic expect_sentence();
        logic [7:0] sum;
        sum  = 8'h00;
        line = '{8'h53, 8'h54, 8'h31, 8'h2C};
        put({24'h0, charge_stage}, 2);
        put({24'h0, charge_fault}, 2);
        put({16'h0, fault_param}, 4);
        put(stage_seconds, 8);
        put({26'h0, data_valid[4], charge_stage == 8'h05 && !can_charger, data_valid[3:0]}, 2);
        put({18'h0, prot_hi, 3'h0, prot_lo}, 4);
        put({26'h0, warn_in[3], 2'h0, warn_in[2:0]}, 2);
        put({21'h0, pin_in & pin_mapped & 11'h7BE}, 8);
        foreach (line[i]) sum += line[i];
        foreach (line[i]) exp_q.push_back(line[i]);
        line.delete();
        put({24'h0, sum}, 2);
        void'(line.pop_back());
        line.push_back(8'h0A);
        foreach (line[i]) exp_q.push_back(line[i]);
    endtask

    task automatic set_fields(input int stg, input int flt, input logic can);
        logic [31:0] v1, v2;
        v1 = $urandom;
        v2 = $urandom;
        @(posedge pclk);
        charge_stage  <= stg[7:0];
        charge_fault  <= flt[7:0];
        can_charger   <= can;
        fault_param   <= v2[31:16];
        stage_seconds <= $urandom;
        {data_valid, prot_lo, prot_hi, warn_in} <= v1[19:0];
        {pin_in, pin_mapped} <= v2[21:0];
        @(posedge pclk);
    endtask

    task automatic wait_done();
        while (exp_q.size() != 0 || tx_valid_q !== 1'b0) @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn, vld_d} = '0;
        {charge_stage, charge_fault, fault_param, stage_seconds, can_charger} = '0;
        {data_valid, prot_lo, prot_hi, warn_in, pin_in, pin_mapped} = '0;
        seed = $urandom(2917);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(bsf_pkg::A_CTRL, 32'h0, 1'b0);
        rd_chk(bsf_pkg::A_PER_ACT, bsf_pkg::PER_ACT_RST, 1'b0);
        rd_chk(bsf_pkg::A_PER_SLP, bsf_pkg::PER_SLP_RST, 1'b0);
        rd_chk(bsf_pkg::A_STAT, 32'h0, 1'b0);
        rd_chk(bsf_pkg::A_IEN, 32'h0, 1'b0);
        rd_chk(bsf_pkg::A_CLR, 32'h0, 1'b0);
        rd_chk(bsf_pkg::A_INFO, 32'h0, 1'b0);
        rd_chk(8'h1C, 32'h0, 1'b1);
        $display("test registers done");
        apb_wr(bsf_pkg::A_IEN, 32'h3);
        dsp.send_line("ST1,X\n");
        repeat (30) @(posedge pclk);
        for (int i = 0; i < 14; i++) begin
            set_fields(i % 7, i % 11, i >= 7);
            expect_sentence();
            dsp.send_line(i == 1 ? "SST1,?\r" : (i[0] ? "ST1,?\r" : "ST1,?\n"));
            wait_done();
            if (i == 0) begin
                `CHK(irq_q, 1'b1)
                rd_chk(bsf_pkg::A_STAT, 32'h3, 1'b0);
                apb_wr(bsf_pkg::A_CLR, 32'h3);
                rd_chk(bsf_pkg::A_STAT, 32'h0, 1'b0);
                `CHK(irq_q, 1'b0)
                apb_wr(bsf_pkg::A_IEN, 32'h0);
            end
        end
        `CHK(irq_q, 1'b0)
        apb_wr(bsf_pkg::A_IEN, 32'h2);
        repeat (2) @(posedge pclk);
        `CHK(irq_q, 1'b1)
        $display("test requests done");
        set_fields(3, 9, 1'b0);
        apb_wr(bsf_pkg::A_PER_ACT, 32'd300);
        apb_wr(bsf_pkg::A_PER_SLP, 32'd400);
        for (int m = 0; m < 2; m++) begin
            starts.delete();
            expect_sentence();
            expect_sentence();
            apb_wr(bsf_pkg::A_CTRL, {30'h0, m[0], 1'b1});
            wait_done();
            apb_wr(bsf_pkg::A_CTRL, 32'h0);
            `CHK(starts.size(), 2)
            `CHK(starts[1] - starts[0], m ? 400 : 300)
            repeat (20) @(posedge pclk);
        end
        $display("test periodic done");
        final_report();
    end
endmodule // bms_status_sentence_framer_tb
